// file: logic/adc_serial_port_config.sv
/*
  Serial output port of the 18-bit converter with pin configuration,
  sticky event status, interrupt and a small register port.
  Assumes the conversion core on ref_clk gives conv_start, conv_done and
  result_in; the host serial clock is much slower than ref_clk.
*/
// The register offsets and the address-and-strobe port were decided locally.
// Notes on behaviour
// - Interface select 0, 1 or 2: shared pins drive parallel bits 4 to 9.
// - Master read-after-convert: divide selects slow the internal serial clock.
// - Other serial configurations: divide pins stay high-impedance.
// - Clock source low: device is master and drives its serial clock.
// - Clock source high: host clocks, gated by chip select; data follows it.
// - Master frame marker active high if polarity select low, else active low.
// - Clock invert select flips serial clock sense in every serial mode.
// - Master read-during-convert: previous result shifts during next conversion, fixed period, divide selects ignored.
// - Master read-after-convert: current result shifts only after conversion ends.
// - Slave: daisy-chain input appears on data output after 18 clock periods.
// - Slave: data updates on rising clock edge, or falling when inverted.
// - Master frame marker asserts at read start, holds while data valid.
// - Most significant bit first; inverted for twos complement when coding select low.
// - Slave read unfinished at conversion end: data dropped, error flag pulses.
`default_nettype none
module adc_serial_port_config
  import serial_port_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Conversion core
  input  wire logic                   conv_start,
  input  wire logic                   conv_done,
  input  wire logic [WORD_BITS-1:0]   result_in,
  // Configuration pins
  input  wire logic [1:0]             interface_select,
  input  wire logic                   output_coding_select,
  // Shared pins, parallel bits 4 to 9 or serial configuration
  input  wire logic [SHARED_PINS-1:0] shared_in,
  output var  logic [SHARED_PINS-1:0] shared_out,
  output var  logic [SHARED_PINS-1:0] shared_oe_n,
  // Serial link
  input  wire logic                   cs_n,
  input  wire logic                   sclk_in,
  output var  logic                   sclk_out,
  output var  logic                   sclk_oe_n,
  output var  logic                   serial_data_output,
  output var  logic                   frame_sync,
  output var  logic                   incomplete_read_flag,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output var  logic [31:0]            reg_rdata,
  // Interrupt
  output var  logic                   irq
);

  // Pin synchronisers
  logic [10:0]            pins_s;
  logic [SHARED_PINS-1:0] cfg;
  logic [1:0]             mode_s;
  logic                   sclk_s;
  logic                   cs_act_s;
  logic                   coding_s;

  pin_sync #(.W(11)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({output_coding_select, ~cs_n, sclk_in, interface_select, shared_in}),
    .sync_out (pins_s)
  );

  assign cfg      = pins_s[5:0];
  assign mode_s   = pins_s[7:6];
  assign sclk_s   = pins_s[8];
  assign cs_act_s = pins_s[9];
  assign coding_s = pins_s[10];

  logic serial;
  logic master;
  logic slave;
  logic read_during_convert;
  logic clk_inv;
  logic frame_pol;
  assign serial    = (mode_s == MODE_SERIAL);
  assign master    = serial && !cfg[PIN_SRC];
  assign slave     = serial && cfg[PIN_SRC];
  assign read_during_convert       = cfg[PIN_RDC];
  assign clk_inv   = cfg[PIN_CINV];
  assign frame_pol = cfg[PIN_FPOL];

  // MSB inverted gives twos complement
  function automatic logic [WORD_BITS-1:0] fmt_word(input logic [WORD_BITS-1:0] w, input logic coding);
    fmt_word = {w[WORD_BITS-1] ^ ~coding, w[WORD_BITS-2:0]};
  endfunction

  function automatic logic [7:0] half_cycles(input logic rd_conv, input logic [1:0] div);
    half_cycles = rd_conv ? RDC_HALF_CYC : 8'(MASTER_HALF_CYC << div);
  endfunction

  // Serial engine state
  mstate_t              m_state_q, m_state_d;
  logic [7:0]           div_q, div_d;
  logic                 m_clk_q, m_clk_d;
  logic [WORD_BITS-1:0] shift_q, shift_d;
  logic [4:0]           cnt_q, cnt_d;
  logic [WORD_BITS-1:0] result_q, result_d;
  logic                 sclk_prev_q, sclk_prev_d;
  logic                 cs_prev_q, cs_prev_d;
  logic                 ev_frame;
  logic                 ev_rderr;
  logic                 m_start;
  logic                 s_active;
  logic                 s_start;
  logic                 s_upd;
  logic [WORD_BITS-1:0] src_word;

  always_comb begin
    m_state_d   = m_state_q;
    div_d       = div_q;
    m_clk_d     = m_clk_q;
    shift_d     = shift_q;
    cnt_d       = cnt_q;
    result_d    = result_q;
    sclk_prev_d = sclk_s;
    cs_prev_d   = cs_act_s;
    ev_frame    = 1'b0;
    ev_rderr    = 1'b0;
    s_active    = slave && cs_act_s && (cnt_q < DAISY_DELAY);
    s_start     = slave && cs_act_s && !cs_prev_q;
    // Slave update edge follows the clock invert select
    s_upd       = slave && cs_act_s && (clk_inv ? (sclk_prev_q && !sclk_s) : (!sclk_prev_q && sclk_s));
    // Read-during-convert sends the stored word; read-after-convert the fresh one
    src_word    = read_during_convert ? result_q : result_in;
    m_start     = master && m_state_q == M_IDLE && (read_during_convert ? conv_start : conv_done);

    if (conv_done) begin
      if (s_active && cnt_q != 5'h00) begin
        ev_rderr = 1'b1;
      end else begin
        result_d = result_in;
      end
    end

    unique case (m_state_q)
      M_IDLE: begin
        m_clk_d = 1'b0;
        if (m_start) begin
          m_state_d = M_SHIFT;
          shift_d   = fmt_word(src_word, coding_s);
          cnt_d     = 5'h00;
          div_d     = half_cycles(read_during_convert, cfg[PIN_DIV1:PIN_DIV0]) - 8'h01;
        end
      end
      M_SHIFT: begin
        if (!master) begin
          m_state_d = M_IDLE;
        end else if (div_q == 8'h00) begin
          div_d   = half_cycles(read_during_convert, cfg[PIN_DIV1:PIN_DIV0]) - 8'h01;
          m_clk_d = !m_clk_q;
          if (m_clk_q) begin
            if (cnt_q == LAST_BIT) begin
              m_state_d = M_IDLE;
              ev_frame  = 1'b1;
            end else begin
              shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
              cnt_d   = cnt_q + 5'h01;
            end
          end
        end else begin
          div_d = div_q - 8'h01;
        end
      end
    endcase

    if (s_start) begin
      shift_d = fmt_word(result_q, coding_s);
      cnt_d   = 5'h00;
    end else if (s_upd) begin
      // Daisy-chain bits enter behind the word, 18 shifts later they reach the pin
      shift_d = {shift_q[WORD_BITS-2:0], cfg[PIN_RDC]};
      if (cnt_q != DAISY_DELAY) begin
        cnt_d = cnt_q + 5'h01;
      end
      if (cnt_q == LAST_BIT) begin
        ev_frame = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      m_state_q   <= M_IDLE;
      div_q       <= 8'h00;
      m_clk_q     <= 1'b0;
      shift_q     <= RESULT_RST;
      cnt_q       <= DAISY_DELAY;
      result_q    <= RESULT_RST;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b0;
    end else begin
      m_state_q   <= m_state_d;
      div_q       <= div_d;
      m_clk_q     <= m_clk_d;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      result_q    <= result_d;
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q   <= cs_prev_d;
    end
  end

  // Pin outputs
  logic [SHARED_PINS-1:0] sh_out_d, sh_oe_n_d;
  logic                   sclk_d, sclk_oe_n_d, sdo_d, fsync_d, rderr_d;

  always_comb begin
    sh_out_d    = result_q[PAR_LSB +: SHARED_PINS];
    // In serial mode every shared pin is an input; divide pins read as high-impedance
    sh_oe_n_d   = serial ? {SHARED_PINS{1'b1}} : {SHARED_PINS{1'b0}};
    sclk_d      = (m_clk_d && master) ^ clk_inv;
    sclk_oe_n_d = !master;
    sdo_d       = serial ? shift_d[WORD_BITS-1] : 1'b0;
    fsync_d     = ((m_state_d == M_SHIFT) && master) ^ frame_pol;
    rderr_d     = ev_rderr;
  end

  logic [SHARED_PINS-1:0] sh_out_q, sh_oe_n_q;
  logic                   sclk_q, sclk_oe_n_q, sdo_q, fsync_q, rderr_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sh_out_q    <= {SHARED_PINS{1'b0}};
      sh_oe_n_q   <= {SHARED_PINS{1'b1}};
      sclk_q      <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      sdo_q       <= 1'b0;
      fsync_q     <= 1'b0;
      rderr_q     <= 1'b0;
    end else begin
      sh_out_q    <= sh_out_d;
      sh_oe_n_q   <= sh_oe_n_d;
      sclk_q      <= sclk_d;
      sclk_oe_n_q <= sclk_oe_n_d;
      sdo_q       <= sdo_d;
      fsync_q     <= fsync_d;
      rderr_q     <= rderr_d;
    end
  end

  assign shared_out           = sh_out_q;
  assign shared_oe_n          = sh_oe_n_q;
  assign sclk_out             = sclk_q;
  assign sclk_oe_n            = sclk_oe_n_q;
  assign serial_data_output   = sdo_q;
  assign frame_sync           = fsync_q;
  assign incomplete_read_flag = rderr_q;

  // Registers, status, interrupt
  logic [1:0]  status_q, status_d, mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        irq_q, irq_d;

  always_comb begin
    mask_d   = mask_q;
    status_d = status_q;
    if (reg_wr && reg_addr == ADDR_MASK) begin
      mask_d = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == ADDR_STATUS) begin
      status_d = status_q & ~reg_wdata[1:0];
    end
    // A new event wins over a clear in the same cycle
    status_d[ST_FRAME] = status_d[ST_FRAME] | ev_frame;
    status_d[ST_RDERR] = status_d[ST_RDERR] | ev_rderr;
    irq_d   = |(status_d & mask_d);
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS: rdata_d = {30'h00000000, status_q};
        ADDR_MASK:   rdata_d = {30'h00000000, mask_q};
        ADDR_STATE:  rdata_d = {16'h0000, cnt_q, 2'h0, m_state_q, mode_s, cfg};
        ADDR_RESULT: rdata_d = {14'h0000, result_q};
        default:     rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
      mask_q   <= MASK_RST;
      rdata_q  <= 32'h00000000;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_par_drive: assert property (!serial |=> shared_oe_n == 6'h00)
    else $error("shared pins not driven in parallel mode");
  chk_div_hiz: assert property (serial && !(master && !read_during_convert) |=> shared_oe_n[1:0] == 2'h3)
    else $error("divide pins driven in serial mode");
  chk_master_clk: assert property (master |=> !sclk_oe_n)
    else $error("master does not drive serial clock");
  chk_slave_clk: assert property (slave |=> sclk_oe_n)
    else $error("slave drives serial clock");
  chk_sync_level: assert property (master && m_state_q == M_IDLE && !m_start |=> frame_sync == $past(frame_pol))
    else $error("frame marker idle level wrong");
  chk_clk_sense: assert property (serial && m_state_q == M_IDLE && !m_start |=> sclk_out == $past(clk_inv))
    else $error("serial clock idle sense wrong");
  chk_rdc_start: assert property (master && read_during_convert && conv_start && m_state_q == M_IDLE |=> m_state_q == M_SHIFT)
    else $error("read during convert did not start");
  chk_rac_start: assert property (master && !read_during_convert && m_state_q == M_IDLE && !conv_done |=> m_state_q == M_IDLE)
    else $error("read after convert started early");
  chk_frame_len: assert property ($fell(m_state_q) && $past(master) |-> $past(cnt_q) == LAST_BIT)
    else $error("master frame ended early");
  chk_frame_hold: assert property (master && m_state_q == M_SHIFT ##1 master
                                   |-> frame_sync == !$past(frame_pol) || m_state_q == M_IDLE)
    else $error("frame marker dropped during frame");
  chk_msb_coding: assert property (m_start && !read_during_convert
                                   |=> serial_data_output == ($past(result_in[17]) ^ !$past(coding_s)))
    else $error("first bit coding wrong");
  chk_rderr_pulse: assert property (conv_done && s_active && cnt_q != 5'h00 |=> incomplete_read_flag ##1 !incomplete_read_flag)
    else $error("incomplete read flag not pulsed");
  chk_rderr_keep: assert property (conv_done && s_active && cnt_q != 5'h00 |=> result_q == $past(result_q))
    else $error("result replaced during slave read");
  // Daisy level enters at the tail and the pin shows the next stage, so the 18-update delay follows
  chk_daisy_pass: assert property (s_upd && !s_start |=> shift_q[0] == $past(cfg[PIN_RDC]) &&
                                   serial_data_output == $past(shift_q[WORD_BITS-2]))
    else $error("daisy input not passed through");
  chk_irq_level: assert property (irq == $past(|(status_d & mask_d)))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// file: logic/serial_port_cfg_pkg.sv
/*
  Constants shared by the serial output port of the 18-bit converter:
  timing, word size, pin positions, register offsets and states.
  Assumes a single 25 MHz clock and the plain register port.
*/
`default_nettype none
package serial_port_cfg_pkg;
  // Clock and serial timing
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          MASTER_HALF_NS  = 40;
  localparam int          RDC_HALF_NS     = 80;
  localparam logic [7:0]  MASTER_HALF_CYC = 8'((MASTER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RDC_HALF_CYC    = 8'((RDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Word and bit counts
  localparam int          WORD_BITS       = 18;
  localparam logic [4:0]  LAST_BIT        = 5'h11;
  localparam logic [4:0]  DAISY_DELAY     = 5'h12;

  // Interface select value that turns the shared pins into serial config
  localparam logic [1:0]  MODE_SERIAL     = 2'h3;

  // Shared pin positions (pins of parallel bits 4 to 9)
  localparam int          PIN_DIV0        = 0;
  localparam int          PIN_DIV1        = 1;
  localparam int          PIN_SRC         = 2;
  localparam int          PIN_FPOL        = 3;
  localparam int          PIN_CINV        = 4;
  localparam int          PIN_RDC         = 5;
  localparam int          SHARED_PINS     = 6;
  localparam int          PAR_LSB         = 4;

  // Register offsets and fields
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;
  localparam logic [3:0]  ADDR_MASK       = 4'h4;
  localparam logic [3:0]  ADDR_STATE      = 4'h8;
  localparam logic [3:0]  ADDR_RESULT     = 4'hc;
  localparam int          ST_FRAME        = 0;
  localparam int          ST_RDERR        = 1;
  localparam logic [1:0]  STATUS_RST      = 2'h0;
  localparam logic [1:0]  MASK_RST        = 2'h0;
  localparam logic [17:0] RESULT_RST      = 18'h00000;

  typedef enum logic [0:0] {
    M_IDLE  = 1'b0,
    M_SHIFT = 1'b1
  } mstate_t;
endpackage
`default_nettype wire

// file: logic/pin_sync.sv
/*
  Two-stage synchroniser bank for pin inputs.
  Assumes inputs are static or slow next to ref_clk; each bit is handled alone.
*/
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      always_comb begin
        meta_d = async_in[i];
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule
`default_nettype wire

// file: test/serial_host_model.sv
/*
  Host end of the serial link: clocks slave reads and captures master frames.
  Assumes the bench calls sel and edges from its main process on ref_clk.
*/
`default_nettype none
module serial_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Link straps as seen by the host
  input  wire logic        inv,
  input  wire logic        fpol,
  // Link pins
  input  wire logic        sclk_out,
  input  wire logic        sdo,
  input  wire logic        frame_sync,
  output var  logic        cs_n,
  output var  logic        sclk_in,
  // Captured words
  output var  logic [17:0] mcap,
  output var  logic [19:0] scap,
  output var  int          mcnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph_q;
  logic act_q;
  initial begin
    cs_n = 1'h1;
    sclk_in = 1'h0;
    mcap = '0;
    scap = '0;
    mcnt = 0;
    ph_q = 1'h0;
    act_q = 1'h0;
  end
  // Master frames: sample on the internal rising edge while the marker is active
  always @(posedge ref_clk) begin
    ph_q <= sclk_out ^ inv;
    act_q <= frame_sync ^ fpol;
    if ((frame_sync ^ fpol) && !act_q) begin
      mcnt <= 0;
    end else if ((frame_sync ^ fpol) && (sclk_out ^ inv) && !ph_q) begin
      mcap <= {mcap[16:0], sdo};
      mcnt <= mcnt + 1;
    end
  end
  // Clock rests at its idle level, so it stands still outside frames
  task automatic sel(input logic v);
    @(posedge ref_clk);
    cs_n <= v;
    sclk_in <= inv;
    repeat (4) @(posedge ref_clk);
    if (!v) scap <= {scap[18:0], sdo};
  endtask
  // Phases of 4 cycles keep each half above the 3-cycle minimum
  task automatic edges(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_in <= ~inv;
      repeat (4) @(posedge ref_clk);
      scap <= {scap[18:0], sdo};
      sclk_in <= inv;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/adc_serial_port_config_bench.sv
/*
  Self-checking bench for the serial port: parallel, master and slave modes.
  Assumes the host model on the link and the plain register port.
*/
`default_nettype none
module adc_serial_port_config_bench import serial_port_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk, rst_n, conv_start, conv_done, coding, cs_n, sclk_in, reg_wr, reg_rd, c, dz;
  logic                   sclk_out, sclk_oe_n, sdo, frame_sync, rd_err, irq;
  logic [WORD_BITS-1:0]   result_in, r1, r2, mcap;
  logic [1:0]             if_sel;
  logic [SHARED_PINS-1:0] shared_in, shared_out, shared_oe_n;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, rv, wv;
  logic [19:0]            scap;
  int                     mcnt, fails, cmp_count, seed, n;

  adc_serial_port_config dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .conv_start(conv_start), .conv_done(conv_done),
    .result_in(result_in), .interface_select(if_sel), .output_coding_select(coding),
    .shared_in(shared_in), .shared_out(shared_out), .shared_oe_n(shared_oe_n),
    .cs_n(cs_n), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .serial_data_output(sdo), .frame_sync(frame_sync), .incomplete_read_flag(rd_err),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );
  serial_host_model host (
    .ref_clk(ref_clk), .inv(shared_in[PIN_CINV]), .fpol(shared_in[PIN_FPOL]),
    .sclk_out(sclk_out), .sdo(sdo), .frame_sync(frame_sync), .cs_n(cs_n),
    .sclk_in(sclk_in), .mcap(mcap), .scap(scap), .mcnt(mcnt)
  );

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [17:0] coded(input logic [17:0] w, input logic cs);
    return cs ? w : {~w[17], w[16:0]};
  endfunction
  function automatic int flen(input logic [1:0] div, input logic read_during_convert);
    return 2 * WORD_BITS * (read_during_convert ? int'(RDC_HALF_CYC) : (int'(MASTER_HALF_CYC) << div));
  endfunction

  task automatic final_report;
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic limit(input int lim);
    if (n >= lim) begin
      fails++;
      final_report;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    rv = reg_rdata;
  endtask
  task automatic conv(input logic done, input logic [17:0] r);
    @(posedge ref_clk);
    result_in <= r;
    if (done) conv_done <= 1'h1;
    else conv_start <= 1'h1;
    @(posedge ref_clk);
    conv_done <= 1'h0;
    conv_start <= 1'h0;
  endtask
  task automatic strap(input logic [5:0] s);
    @(posedge ref_clk);
    shared_in <= s;
    coding <= c;
    tick(6);
  endtask

  task automatic master(input logic [1:0] div, input logic read_during_convert, input logic fpol, input logic inv);
    r1 = 18'($random(seed));
    r2 = 18'($random(seed));
    c = 1'($random(seed));
    strap({read_during_convert, inv, fpol, 1'h0, div});
    chk("sclk_oe_n", 36'h0, sclk_oe_n);
    chk("shared_oe_n", 36'h3f, shared_oe_n);
    chk("sync idle", fpol, frame_sync);
    chk("sclk idle", inv, sclk_out);
    if (!read_during_convert) begin
      conv(1'h0, r2);
      tick(3);
      chk("early frame", fpol, frame_sync);
    end
    conv(1'h1, r1);
    if (read_during_convert) conv(1'h0, r2);
    for (n = 0; frame_sync !== ~fpol && n < 5; n++) @(posedge ref_clk);
    limit(5);
    for (n = 0; frame_sync === ~fpol && n < 400; n++) @(posedge ref_clk);
    limit(400);
    chk("frame length", 36'(flen(div, read_during_convert)), 36'(n));
    chk("master word", coded(r1, c), mcap);
    chk("master bits", 36'd18, 36'(mcnt));
    rd(ADDR_STATUS);
    chk("frame status", 36'h1, rv[1:0]);
    chk("masked irq", 36'h0, irq);
    wr(ADDR_STATUS, 32'h1);
  endtask

  task automatic slave(input logic inv);
    r1 = 18'($random(seed));
    c = 1'($random(seed));
    dz = 1'($random(seed));
    strap({dz, inv, 1'h0, 1'h1, 2'h0});
    chk("sclk_oe_n", 36'h1, sclk_oe_n);
    chk("shared_oe_n", 36'h3f, shared_oe_n);
    conv(1'h1, r1);
    host.sel(1'h0);
    host.edges(19);
    host.sel(1'h1);
    chk("slave word", {coded(r1, c), dz, dz}, scap);
  endtask

  initial begin
    seed = 4029;
    fails = 0;
    cmp_count = 0;
    rst_n = 1'h0;
    conv_start = 1'h0;
    conv_done = 1'h0;
    result_in = '0;
    if_sel = 2'h0;
    coding = 1'h1;
    c = 1'h1;
    shared_in = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    tick(5);
    rst_n <= 1'h1;
    rd(ADDR_STATUS);
    chk("status reset", 36'h0, rv);
    rd(ADDR_MASK);
    chk("mask reset", 36'h0, rv);
    wv = 32'($random(seed));
    wr(ADDR_MASK, wv);
    rd(ADDR_MASK);
    chk("mask write", 36'(wv[1:0]), rv);
    rd(4'($random(seed)) | 4'h1);
    chk("unmapped", 36'h0, rv);
    // Reset in mid-run must bring the mask back to zero
    @(posedge ref_clk);
    rst_n <= 1'h0;
    tick(3);
    rst_n <= 1'h1;
    rd(ADDR_MASK);
    chk("mask after reset", 36'h0, rv);
    for (int i = 0; i < 3; i++) begin
      r1 = 18'($random(seed));
      if_sel <= 2'(i);
      tick(6);
      conv(1'h1, r1);
      tick(3);
      chk("par oe", 36'h0, shared_oe_n);
      chk("par data", r1[9:4], shared_out);
    end
    if_sel <= MODE_SERIAL;
    for (int d = 0; d < 4; d++) master(d[1:0], 1'h0, d[0], d[1]);
    master(2'h1, 1'h1, 1'h1, 1'h0);
    slave(1'h0);
    slave(1'h1);
    c = 1'h1;
    strap(6'h04);
    r1 = 18'h2a5c3;
    conv(1'h1, r1);
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_MASK, 32'h3);
    rd(ADDR_MASK);
    chk("mask", 36'h3, rv);
    host.sel(1'h0);
    host.edges(5);
    conv(1'h1, 18'h15a3c);
    for (n = 0; rd_err !== 1'h1 && n < 6; n++) @(posedge ref_clk);
    limit(6);
    @(posedge ref_clk);
    chk("flag pulse", 36'h0, rd_err);
    host.sel(1'h1);
    rd(ADDR_STATUS);
    chk("error status", 36'h1, rv[1]);
    chk("irq", 36'h1, irq);
    wr(ADDR_STATUS, 32'h3);
    tick(2);
    chk("irq clear", 36'h0, irq);
    host.sel(1'h0);
    host.edges(17);
    host.sel(1'h1);
    chk("kept word", r1, scap[17:0]);
    rd(ADDR_RESULT);
    chk("stored word", r1, rv);
    rd(ADDR_STATE);
    chk("state", 36'h88c4, rv);
    final_report;
  end
endmodule
`default_nettype wire
